// [design/wru_top.sv]
// Controller-area read: fetch words at I/O refresh and unpack them
`timescale 1ns/10ps
`default_nettype none
`include "wru_params.svh"
module wru_top #(
	parameter int FIFO_DEPTH = `WRU_FIFO_DEPTH
) (
	input  wire logic               sys_clk,           // Unit clock, 100 MHz
	input  wire logic               srst,              // Synchronous reset
	input  wire logic               prog_req,          // Program issues a read
	input  wire wru_pkg::wru_spec_t prog_spec,         // Format spec with request
	output logic                    prog_hold,         // Program stalled
	output logic                    result_valid,      // Result code valid
	output logic [7:0]              result_code,       // 0 ok, -1 refused
	output logic                    format_error,      // Spec rejected
	input  wire logic [15:0]        unit_control_word, // Host control word
	input  wire logic [15:0]        source_area_word,  // Host source area
	input  wire logic [15:0]        source_count_word, // Host word count
	input  wire logic               io_refresh,        // I/O refresh strobe
	output logic                    fetch_req,         // Fetch command pulse
	output wru_pkg::wru_fetch_t     fetch_cmd,         // Area and count
	input  wire logic               host_word_valid,   // Host word valid
	output logic                    host_word_ready,   // Room in buffer
	input  wire logic [15:0]        host_word_data,    // Host word
	output logic                    elem_valid,        // Element valid
	input  wire logic               elem_ready,        // Engine takes element
	output wru_pkg::wru_elem_t      elem               // Element to store
);
	// ==========================================================
	// Declarations
	wru_pkg::wru_state_t st_reg;
	wru_pkg::wru_fmt_t   cfg_fmt_reg;
	logic [3:0]          cfg_arg_reg;
	logic [7:0]          limit_reg;
	logic [7:0]          fetch_cnt_reg;
	logic [7:0]          recv_cnt_reg;
	logic                err_reg;
	logic                busy_pend_reg;
	logic                prog_hold_reg;
	logic                result_valid_reg;
	logic [7:0]          result_code_reg;
	logic                format_error_reg;
	logic                fetch_req_reg;
	wru_pkg::wru_fetch_t fetch_reg;
	logic                elem_valid_reg;
	wru_pkg::wru_elem_t  elem_reg;

	logic [3:0]          num_top;
	logic [3:0]          num_sub;
	logic [7:0]          eff_count;
	wru_pkg::wru_fmt_t   dec_fmt;
	logic [3:0]          dec_arg;
	logic [7:0]          dec_limit;
	logic                dec_ok;
	logic [7:0]          capped_cnt;

	logic                fifo_valid;
	logic [15:0]         fifo_data;
	logic                pop;
	logic                last_word;
	logic                done_go;
	logic                busy_req;
	logic [15:0]         conv_val;
	logic [1:0]          conv_chars;

	assign prog_hold = prog_hold_reg;
	assign result_valid = result_valid_reg;
	assign result_code = result_code_reg;
	assign format_error = format_error_reg;
	assign fetch_req = fetch_req_reg;
	assign fetch_cmd = fetch_reg;
	assign elem_valid = elem_valid_reg;
	assign elem = elem_reg;

	// ==========================================================
	// Spec decode
	// Maps a numeric type letter to {ok, format}; anything but the
	// uppercase letters I, H, O and B is refused
	function automatic logic [3:0] num_letter(input logic [7:0] ch);
		case (ch)
			`WRU_CH_I: num_letter = {1'b1, wru_pkg::FMT_DEC};
			`WRU_CH_H: num_letter = {1'b1, wru_pkg::FMT_HEX};
			`WRU_CH_O: num_letter = {1'b1, wru_pkg::FMT_OCT};
			`WRU_CH_B: num_letter = {1'b1, wru_pkg::FMT_BIT};
			default: num_letter = 4'h0;
		endcase
	endfunction

	always_comb begin
		num_top = num_letter(prog_spec.fmt_letter);
		num_sub = num_letter(prog_spec.sub_letter);
		eff_count = (prog_spec.word_count == 8'h00) ? `WRU_DEF_COUNT
			: prog_spec.word_count;
		dec_fmt = wru_pkg::wru_fmt_t'(num_top[2:0]);
		dec_arg = prog_spec.fmt_arg[3:0];
		dec_limit = (eff_count < prog_spec.dest_elems) ? eff_count
			: prog_spec.dest_elems;
		dec_ok = !prog_spec.dest_is_string
			&& (prog_spec.dest_elems != 8'h00);
		if (prog_spec.fmt_letter == `WRU_CH_A) begin
			dec_fmt = wru_pkg::FMT_CHR;
			dec_limit = eff_count;
			dec_ok = prog_spec.dest_is_string
				&& (prog_spec.dest_elems == 8'h01)
				&& (eff_count <= `WRU_MAX_CHARS)
				&& (prog_spec.fmt_arg >= 8'h01)
				&& (prog_spec.fmt_arg <= 8'h03);
		end else if (prog_spec.fmt_letter == `WRU_CH_S) begin
			dec_fmt = wru_pkg::wru_fmt_t'(num_sub[2:0]);
			dec_arg = (wru_pkg::wru_fmt_t'(num_sub[2:0]) == wru_pkg::FMT_BIT)
				? 4'h0 : 4'h4;
			dec_limit = eff_count;
			dec_ok = num_sub[3] && !prog_spec.dest_is_string
				&& (prog_spec.dest_elems == eff_count)
				&& (prog_spec.fmt_arg == eff_count);
		end else if (dec_fmt == wru_pkg::FMT_BIT) begin
			dec_ok = dec_ok && num_top[3]
				&& (prog_spec.fmt_arg <= 8'h0f);
		end else begin
			dec_ok = dec_ok && num_top[3]
				&& (prog_spec.fmt_arg >= 8'h01)
				&& (prog_spec.fmt_arg <= 8'h04);
		end
	end

	// Large host counts are clipped so one read never exceeds the limit
	assign capped_cnt = (source_count_word > {8'h00, `WRU_MAX_XFER})
		? `WRU_MAX_XFER : source_count_word[7:0];

	// ==========================================================
	// Word path
	assign pop = fifo_valid && (st_reg == wru_pkg::ST_DRAIN)
		&& (!elem_valid_reg || elem_ready);
	assign last_word = (8'(recv_cnt_reg + 8'h01) == fetch_cnt_reg);
	assign done_go = (st_reg == wru_pkg::ST_DONE)
		&& (!elem_valid_reg || elem_ready);
	assign busy_req = prog_req && (st_reg != wru_pkg::ST_IDLE);

	// Host words are buffered so a slow program engine back-pressures
	// the refresh transfer instead of losing words
	wru_fifo #(
		.W     (16),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_valid  (host_word_valid),
		.in_ready  (host_word_ready),
		.in_data   (host_word_data),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	wru_unpack u_unpack (
		.word  (fifo_data),
		.fmt   (cfg_fmt_reg),
		.arg   (cfg_arg_reg),
		.value (conv_val),
		.chars (conv_chars)
	);

	// ==========================================================
	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_reg <= wru_pkg::ST_IDLE;
		end else begin
			unique case (st_reg)
				wru_pkg::ST_IDLE: begin
					if (prog_req) begin
						st_reg <= dec_ok ? wru_pkg::ST_ARM : wru_pkg::ST_DONE;
					end
				end
				wru_pkg::ST_ARM: begin
					if (io_refresh && unit_control_word[`WRU_REQ_BIT]) begin
						st_reg <= wru_pkg::ST_FETCH;
					end
				end
				wru_pkg::ST_FETCH: begin
					st_reg <= (fetch_cnt_reg == 8'h00) ? wru_pkg::ST_DONE
						: wru_pkg::ST_DRAIN;
				end
				wru_pkg::ST_DRAIN: begin
					if (pop && last_word) begin
						st_reg <= wru_pkg::ST_DONE;
					end
				end
				wru_pkg::ST_DONE: begin
					if (done_go) begin
						st_reg <= wru_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Spec is latched on acceptance so the engine may change it afterwards
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cfg_fmt_reg <= wru_pkg::FMT_DEC;
			cfg_arg_reg <= 4'h0;
			limit_reg <= 8'h00;
			err_reg <= 1'b0;
		end else if (prog_req && (st_reg == wru_pkg::ST_IDLE)) begin
			cfg_fmt_reg <= dec_fmt;
			cfg_arg_reg <= dec_arg;
			limit_reg <= dec_limit;
			err_reg <= !dec_ok;
		end
	end

	// ==========================================================
	// Fetch command
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fetch_req_reg <= 1'b0;
			fetch_reg <= '0;
			fetch_cnt_reg <= 8'h00;
		end else begin
			fetch_req_reg <= 1'b0;
			if ((st_reg == wru_pkg::ST_ARM) && io_refresh
				&& unit_control_word[`WRU_REQ_BIT]) begin
				fetch_req_reg <= 1'b1;
				fetch_reg.area <= source_area_word;
				fetch_reg.count <= capped_cnt;
				fetch_cnt_reg <= capped_cnt;
			end
		end
	end

	// ==========================================================
	// Element output
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			recv_cnt_reg <= 8'h00;
		end else if (st_reg == wru_pkg::ST_FETCH) begin
			recv_cnt_reg <= 8'h00;
		end else if (pop) begin
			recv_cnt_reg <= 8'(recv_cnt_reg + 8'h01);
		end
	end

	// Words past the destination are still drained, just not delivered
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			elem_valid_reg <= 1'b0;
			elem_reg <= '0;
		end else if (pop && (recv_cnt_reg < limit_reg)) begin
			elem_valid_reg <= 1'b1;
			elem_reg.value <= conv_val;
			elem_reg.chars <= conv_chars;
			elem_reg.index <= recv_cnt_reg;
		end else if (elem_ready) begin
			elem_valid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Program handshake
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_hold_reg <= 1'b0;
		end else if (prog_req && (st_reg == wru_pkg::ST_IDLE)) begin
			prog_hold_reg <= 1'b1;
		end else if (done_go) begin
			prog_hold_reg <= 1'b0;
		end
	end

	// A refused request may coincide with a completion; it is held over
	// one cycle so both results reach the engine
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_pend_reg <= 1'b0;
		end else if (busy_req) begin
			busy_pend_reg <= 1'b1;
		end else if (!done_go) begin
			busy_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result_valid_reg <= 1'b0;
			result_code_reg <= `WRU_RES_OK;
		end else if (done_go) begin
			result_valid_reg <= 1'b1;
			result_code_reg <= err_reg ? `WRU_RES_FAIL : `WRU_RES_OK;
		end else if (busy_pend_reg) begin
			result_valid_reg <= 1'b1;
			result_code_reg <= `WRU_RES_FAIL;
		end else begin
			result_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			format_error_reg <= 1'b0;
		end else begin
			format_error_reg <= prog_req && (st_reg == wru_pkg::ST_IDLE)
				&& !dec_ok;
		end
	end

	// ==========================================================
	// Assertions
	// Conversion checks look only at a popped word: an empty head slot holds no data
	AST_BIT_EXTRACT: assert property (
		@(posedge sys_clk) disable iff (srst)
		pop && (cfg_fmt_reg == wru_pkg::FMT_BIT)
		|-> conv_val == {15'h0000, fifo_data[cfg_arg_reg]})
		else $error("bit format returned wrong bit");

	AST_HEX_MASK: assert property (
		@(posedge sys_clk) disable iff (srst)
		pop && (cfg_fmt_reg == wru_pkg::FMT_HEX) && (cfg_arg_reg == 4'h3)
		|-> conv_val == {4'h0, fifo_data[11:0]})
		else $error("three digits did not take bits 0-11");

	AST_CHAR_HIGH: assert property (
		@(posedge sys_clk) disable iff (srst)
		pop && (cfg_fmt_reg == wru_pkg::FMT_CHR) && (cfg_arg_reg == 4'h2)
		|-> (conv_val == {8'h00, fifo_data[15:8]}) && (conv_chars == 2'h1))
		else $error("selector 2 did not take high byte");

	AST_XFER_CAP: assert property (
		@(posedge sys_clk) disable iff (srst)
		fetch_req_reg |-> (fetch_reg.count <= 8'h7f)
			&& (fetch_reg.count == fetch_cnt_reg))
		else $error("fetch count above limit");

	AST_DEFAULT_COUNT: assert property (
		@(posedge sys_clk) disable iff (srst)
		prog_req && (st_reg == wru_pkg::ST_IDLE) && dec_ok
			&& (prog_spec.word_count == 8'h00)
			&& (prog_spec.fmt_letter != `WRU_CH_S)
		|=> limit_reg == 8'h01)
		else $error("absent count not taken as one");

	AST_OK_RESULT: assert property (
		@(posedge sys_clk) disable iff (srst)
		done_go && !err_reg
		|=> result_valid_reg && (result_code_reg == 8'h00) && !prog_hold_reg)
		else $error("completion did not report zero");

	AST_BUSY_RESULT: assert property (
		@(posedge sys_clk) disable iff (srst)
		busy_req |-> ##[2:3] (result_valid_reg && (result_code_reg == 8'hff)))
		else $error("busy request not refused");

	AST_REFRESH_START: assert property (
		@(posedge sys_clk) disable iff (srst)
		$rose(fetch_req_reg)
		|-> $past(io_refresh) && $past(unit_control_word[1])
			&& (fetch_reg.area == $past(source_area_word)))
		else $error("fetch not started at refresh with request");

	AST_HOLD_BUSY: assert property (
		@(posedge sys_clk) disable iff (srst)
		(st_reg == wru_pkg::ST_FETCH) |-> prog_hold_reg [*2])
		else $error("program released during transfer");

	AST_SURPLUS_DROP: assert property (
		@(posedge sys_clk) disable iff (srst)
		pop && (recv_cnt_reg >= limit_reg) && elem_ready
		|=> !elem_valid_reg)
		else $error("surplus word delivered");

	AST_FORMAT_ERR: assert property (
		@(posedge sys_clk) disable iff (srst)
		prog_req && (st_reg == wru_pkg::ST_IDLE) && !dec_ok
		|=> format_error_reg ##1 (result_valid_reg && (result_code_reg == 8'hff)))
		else $error("bad spec not flagged");
endmodule
`default_nettype wire

// [design/wru_params.svh]
// Constants for the controller-area read unpacker
// How it works
// - Bit format returns chosen bit 0..15
// - Two, three, four digits take low bits
// - Character selector picks low, high, both bytes
// - Array format converts words into successive elements
// - At most 127 words per read
// - Missing word count means one word
// - Counts 1..255 numeric, 1..64 character
// - Plain formats map one word per variable
// - Several variables may share one entry
// - One entry per string or array
// - Format letters recognised uppercase only
// - Destination type and size must match
// - Completed read returns result zero
// - Refused read returns result minus one
// - Host requests read on control bit 1
// - Source area and count from host words
// - Words move at next I/O refresh
// - Program held until transfer completes
// - Surplus words beyond destination are dropped
// - Element count mismatch raises format error
`ifndef WRU_PARAMS_SVH
`define WRU_PARAMS_SVH
`define WRU_REQ_BIT 1
`define WRU_MAX_XFER 8'h7f
`define WRU_MAX_CHARS 8'h40
`define WRU_DEF_COUNT 8'h01
`define WRU_RES_OK 8'h00
`define WRU_RES_FAIL 8'hff
`define WRU_CH_I 8'h49
`define WRU_CH_H 8'h48
`define WRU_CH_O 8'h4f
`define WRU_CH_B 8'h42
`define WRU_CH_A 8'h41
`define WRU_CH_S 8'h53
`define WRU_FIFO_DEPTH 16
`endif

// [design/wru_pkg.sv]
// Types shared by the controller-area read unpacker
`default_nettype none
package wru_pkg;
	typedef enum logic [2:0] {
		FMT_DEC = 3'h0,
		FMT_HEX = 3'h1,
		FMT_OCT = 3'h2,
		FMT_BIT = 3'h3,
		FMT_CHR = 3'h4
	} wru_fmt_t;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_ARM   = 5'h02,
		ST_FETCH = 5'h04,
		ST_DRAIN = 5'h08,
		ST_DONE  = 5'h10
	} wru_state_t;
	typedef struct packed {
		logic [7:0] fmt_letter;
		logic [7:0] sub_letter;
		logic [7:0] word_count;
		logic [7:0] fmt_arg;
		logic [7:0] dest_elems;
		logic       dest_is_string;
	} wru_spec_t;
	typedef struct packed {
		logic [15:0] value;
		logic [1:0]  chars;
		logic [7:0]  index;
	} wru_elem_t;
	typedef struct packed {
		logic [15:0] area;
		logic [7:0]  count;
	} wru_fetch_t;
endpackage
`default_nettype wire

// [design/wru_fifo.sv]
// Word FIFO between the host refresh path and the unpacker
`timescale 1ns/10ps
`default_nettype none
module wru_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic         sys_clk,   // Unit clock
	input  wire logic         srst,      // Synchronous reset
	input  wire logic         in_valid,  // Write word valid
	output logic              in_ready,  // Room for a word
	input  wire logic [W-1:0] in_data,   // Write word
	output logic              out_valid, // Head word valid
	input  wire logic         out_ready, // Reader takes head
	output logic [W-1:0]      out_data   // Head word
);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	logic [AW:0]   count_next;
	logic          push;
	logic          pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_ptr_reg];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Flags are registered from the next count so both ports see flop outputs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_next;
			in_ready <= count_next != (AW+1)'(DEPTH);
			out_valid <= count_next != '0;
		end
	end

	AST_FIFO_FULL: assert property (@(posedge sys_clk) disable iff (srst)
		(count_reg == (AW+1)'(DEPTH)) |-> !in_ready && out_valid)
		else $error("fifo full but still ready");
endmodule
`default_nettype wire

// [design/wru_unpack.sv]
// Word-to-value conversion for one fetched word
`timescale 1ns/10ps
`default_nettype none
module wru_unpack (
	input  wire logic [15:0]       word,  // Fetched word
	input  wire wru_pkg::wru_fmt_t fmt,   // Conversion format
	input  wire logic [3:0]        arg,   // Digits, bit or selector
	output logic [15:0]            value, // Converted value
	output logic [1:0]             chars  // Characters produced
);
	logic [15:0] hmask;
	logic [15:0] omask;
	logic [15:0] m;

	always_comb begin
		case (arg[2:0])
			3'h1: hmask = 16'h000f;
			3'h2: hmask = 16'h00ff;
			3'h3: hmask = 16'h0fff;
			default: hmask = 16'hffff;
		endcase
		case (arg[2:0])
			3'h1: omask = 16'h0007;
			3'h2: omask = 16'h003f;
			3'h3: omask = 16'h01ff;
			default: omask = 16'h0fff;
		endcase
		m = word & hmask;
		value = m;
		chars = 2'h0;
		case (fmt)
			wru_pkg::FMT_DEC: value = 16'(m[3:0]) + 16'(m[7:4]) * 16'h000a
				+ 16'(m[11:8]) * 16'h0064 + 16'(m[15:12]) * 16'h03e8;
			wru_pkg::FMT_OCT: value = word & omask;
			wru_pkg::FMT_BIT: value = {15'h0000, word[arg]};
			wru_pkg::FMT_CHR: begin
				chars = (arg[1:0] == 2'h3) ? 2'h2 : 2'h1;
				value = (arg[1:0] == 2'h1) ? {8'h00, word[7:0]} :
					(arg[1:0] == 2'h2) ? {8'h00, word[15:8]} : word;
			end
			default: value = m;
		endcase
	end
endmodule
`default_nettype wire

// [sim/wru_host_model.sv]
// Host CPU model: control words, refresh strobe and word stream
`timescale 1ns/10ps
`default_nettype none
module wru_host_model (
	input  wire logic                sys_clk,   // Unit clock
	input  wire logic                srst,      // Synchronous reset
	input  wire logic                req_on,    // Bench raises read request
	input  wire logic                slow,      // Gaps between words
	input  wire logic [15:0]         area,      // Source area to publish
	input  wire logic [15:0]         count,     // Word count to publish
	output logic [15:0]              ctrl,      // Control word
	output logic [15:0]              area_w,    // Source area word
	output logic [15:0]              count_w,   // Source count word
	output logic                     refresh,   // I/O refresh strobe
	input  wire logic                fetch_req, // Fetch command pulse
	input  wire wru_pkg::wru_fetch_t fetch_cmd, // Area and count
	output logic                     wvalid,    // Word valid
	input  wire logic                wready,    // Buffer room
	output logic [15:0]              wdata      // Word
);
	logic [2:0] tick;
	logic [7:0] left;
	logic [7:0] k;
	logic [1:0] gap;
	// ==========================================
	// Control words
	assign ctrl = {14'h0000, req_on, 1'b0};
	assign area_w = area;
	assign count_w = count;
	// ==========================================
	// Refresh and word stream
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tick <= 3'h0;
			refresh <= 1'b0;
			wvalid <= 1'b0;
			left <= 8'h00;
			k <= 8'h00;
			gap <= 2'h0;
			wdata <= 16'h5a5a;
		end else begin
			tick <= tick + 3'h1;
			refresh <= (tick == 3'h7);
			if (fetch_req) begin
				left <= fetch_cmd.count;
				k <= 8'h00;
			end else if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
				left <= left - 8'h01;
				k <= k + 8'h01;
				gap <= slow ? 2'h3 : 2'h0;
			end else if (!wvalid && left != 8'h00 && gap == 2'h0) begin
				wvalid <= 1'b1;
				wdata <= fetch_cmd.area + 16'(k) * 16'h1357;
			end else if (!wvalid) begin
				// Released line keeps toggling so stale data never looks valid
				wdata <= ~wdata;
				if (gap != 2'h0) gap <= gap - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [sim/test_wru_top.sv]
// Testbench for the controller-area read unpacker
`timescale 1ns/10ps
`default_nettype none
module test_wru_top;
	logic sys_clk = 0, srst = 1, prog_req = 0, elem_ready = 1, req_on = 0, slow = 0;
	logic stall = 0, ferr = 0, saw_full = 0;
	logic [15:0] area = 16'h0000, count = 16'h0000;
	wru_pkg::wru_spec_t prog_spec = '0;
	logic prog_hold, result_valid, format_error, io_refresh, fetch_req;
	logic host_word_valid, host_word_ready, elem_valid;
	logic [7:0] result_code;
	logic [15:0] unit_control_word, source_area_word, source_count_word, host_word_data;
	wru_pkg::wru_fetch_t fetch_cmd;
	wru_pkg::wru_elem_t elem;
	int num_errors = 0, samples_checked = 0, cycles = 0;
	// ==========================================
	// Clock, design and host
	always #5 sys_clk = ~sys_clk;
	wru_top #(.FIFO_DEPTH(16)) i_dut (.sys_clk(sys_clk), .srst(srst), .prog_req(prog_req),
		.prog_spec(prog_spec), .prog_hold(prog_hold), .result_valid(result_valid),
		.result_code(result_code), .format_error(format_error),
		.unit_control_word(unit_control_word), .source_area_word(source_area_word),
		.source_count_word(source_count_word), .io_refresh(io_refresh),
		.fetch_req(fetch_req), .fetch_cmd(fetch_cmd), .host_word_valid(host_word_valid),
		.host_word_ready(host_word_ready), .host_word_data(host_word_data),
		.elem_valid(elem_valid), .elem_ready(elem_ready), .elem(elem));
	wru_host_model i_host (.sys_clk(sys_clk), .srst(srst), .req_on(req_on), .slow(slow),
		.area(area), .count(count), .ctrl(unit_control_word), .area_w(source_area_word),
		.count_w(source_count_word), .refresh(io_refresh), .fetch_req(fetch_req),
		.fetch_cmd(fetch_cmd), .wvalid(host_word_valid), .wready(host_word_ready),
		.wdata(host_word_data));
	always @(negedge sys_clk) if (!srst && host_word_ready === 1'b0) saw_full <= 1'b1;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			finish_test();
		end
	end
	// ==========================================
	// Helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [15:0] conv(input logic [7:0] f, input logic [3:0] a,
		input logic [15:0] w);
		logic [15:0] m, v;
		m = (a >= 4) ? 16'hffff : (16'h0001 << (4 * a)) - 16'h0001;
		v = 16'h0000;
		for (int i = 3; i >= 0; i--) begin
			if (f == "I") v = v * 10 + (((w & m) >> (4 * i)) & 16'h000f);
		end
		if (f == "H") v = w & m;
		// Octal digits are consecutive three-bit groups from bit 0
		if (f == "O") v = w & ((a >= 4) ? 16'h0fff : (16'h0001 << (3 * a)) - 16'h0001);
		if (f == "B") v = {15'h0000, w[a]};
		if (f == "A") v = (a == 1) ? (w & 16'h00ff) : (a == 2) ? (w >> 8) : w;
		return v;
	endfunction
	task automatic start_read(input logic [7:0] f, s, c, a, e, input logic str,
		input logic [15:0] src, input logic go);
		@(posedge sys_clk);
		prog_spec <= '{f, s, c, a, e, str};
		prog_req <= 1'b1;
		area <= {f, a};
		count <= src;
		req_on <= go;
		@(posedge sys_clk);
		prog_req <= 1'b0;
	endtask
	// Collects elements until the result pulse; hold checked while a good read runs
	task automatic finish_read(input logic [7:0] f, input logic [3:0] a, input int exp_n,
		input logic [7:0] code);
		int n, t;
		bit done;
		n = 0;
		t = 0;
		done = 0;
		ferr = 0;
		while (!done) begin
			@(negedge sys_clk);
			if (format_error === 1'b1) ferr = 1;
			if (fetch_req === 1'b1) begin
				check("fetch count", 16'(fetch_cmd.count), count > 127 ? 16'h007f : count);
				check("fetch area", fetch_cmd.area, area);
			end
			if (elem_valid === 1'b1 && elem_ready) begin
				check("index", 16'(elem.index), 16'(n));
				check("value", elem.value, conv(f, a, area + 16'(n) * 16'h1357));
				if (f == "A") check("chars", 16'(elem.chars), a == 3 ? 16'h0002 : 16'h0001);
				n++;
			end
			if (result_valid === 1'b1) begin
				done = 1;
				check("result", 16'(result_code), 16'(code));
				check("hold end", 16'(prog_hold), 16'h0000);
			end else if (code == 8'h00) check("hold", 16'(prog_hold), 16'h0001);
			@(posedge sys_clk);
			elem_ready <= !stall || (t % 40 > 29);
			t++;
		end
		check("elements", 16'(n), 16'(exp_n));
		req_on <= 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task t_formats;
		logic [7:0] fl [10] = '{"I", "I", "H", "H", "O", "B", "B", "A", "A", "A"};
		logic [3:0] al [10] = '{4'h2, 4'h4, 4'h3, 4'h4, 4'h4, 4'h0, 4'hf, 4'h1, 4'h2, 4'h3};
		foreach (fl[i]) begin
			start_read(fl[i], 8'h00, 8'h02, {4'h0, al[i]}, fl[i] == "A" ? 8'h01 : 8'h02,
				fl[i] == "A", 16'h0002, 1'b1);
			finish_read(fl[i], al[i], 2, 8'h00);
		end
		$display("test formats done");
	endtask
	task t_array;
		logic [7:0] sl [4] = '{"I", "H", "O", "B"};
		slow <= 1'b1;
		foreach (sl[i]) begin
			start_read("S", sl[i], 8'h03, 8'h03, 8'h03, 1'b0, 16'h0003, 1'b1);
			finish_read(sl[i], sl[i] == "B" ? 4'h0 : 4'h4, 3, 8'h00);
		end
		slow <= 1'b0;
		$display("test array done");
	endtask
	task t_count;
		start_read("H", 8'h00, 8'h00, 8'h04, 8'h04, 1'b0, 16'h0003, 1'b1);
		finish_read("H", 4'h4, 1, 8'h00);
		start_read("H", 8'h00, 8'h04, 8'h04, 8'h02, 1'b0, 16'h0004, 1'b1);
		finish_read("H", 4'h4, 2, 8'h00);
		$display("test count done");
	endtask
	task t_errors;
		start_read("h", 8'h00, 8'h02, 8'h04, 8'h02, 1'b0, 16'h0002, 1'b0);
		finish_read("H", 4'h4, 0, 8'hff);
		check("lower case", 16'(ferr), 16'h0001);
		start_read("S", "H", 8'h03, 8'h02, 8'h03, 1'b0, 16'h0003, 1'b0);
		finish_read("H", 4'h4, 0, 8'hff);
		check("elem mismatch", 16'(ferr), 16'h0001);
		start_read("A", 8'h00, 8'h41, 8'h03, 8'h01, 1'b1, 16'h0041, 1'b0);
		finish_read("A", 4'h3, 0, 8'hff);
		check("char count", 16'(ferr), 16'h0001);
		$display("test errors done");
	endtask
	task t_busy;
		start_read("H", 8'h00, 8'h02, 8'h04, 8'h02, 1'b0, 16'h0002, 1'b0);
		repeat (20) begin
			@(negedge sys_clk);
			check("early fetch", 16'(fetch_req), 16'h0000);
			check("busy hold", 16'(prog_hold), 16'h0001);
		end
		@(posedge sys_clk);
		prog_req <= 1'b1;
		@(posedge sys_clk);
		prog_req <= 1'b0;
		ferr = 0;
		repeat (3) begin
			@(negedge sys_clk);
			if (result_valid === 1'b1 && result_code === 8'hff) ferr = 1;
		end
		check("refused", 16'(ferr), 16'h0001);
		req_on <= 1'b1;
		finish_read("H", 4'h4, 2, 8'h00);
		$display("test busy done");
	endtask
	task t_max;
		stall <= 1'b1;
		start_read("H", 8'h00, 8'hff, 8'h04, 8'hff, 1'b0, 16'h00c8, 1'b1);
		finish_read("H", 4'h4, 127, 8'h00);
		check("buffer full", 16'(saw_full), 16'h0001);
		stall <= 1'b0;
		$display("test max done");
	endtask
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		t_formats();
		t_array();
		t_count();
		t_errors();
		t_busy();
		t_max();
		finish_test();
	end
endmodule
`default_nettype wire
